//--- src/charge_mode_pkg.sv
// constants and types for the charge mode control logic
package charge_mode_pkg;
    // 34-stage timer divider
    localparam int          TIMER_STAGES     = 34;
    localparam int          SW1_BYPASS       = 19;
    localparam int          SW2_BYPASS       = 11;
    localparam int          GATE_BYPASS      = 5;
    localparam int          HOLD_BYPASS      = 11;
    localparam int          GATE_STAGES      = 20;
    localparam int          HOLD_STAGES      = 24;
    // limits in minutes, indexed by {lower, thermistor, upper} programming inputs
    localparam int          LIMIT_283_MIN    = 283;
    localparam int          LIMIT_247_MIN    = 247;
    localparam int          LIMIT_212_MIN    = 212;
    localparam int          LIMIT_177_MIN    = 177;
    localparam int          LIMIT_141_MIN    = 141;
    localparam int          LIMIT_106_MIN    = 106;
    localparam int          LIMIT_71_MIN     = 71;
    localparam int          SLOPE_EVENTS     = 2;
    // interrupt/status register map
    localparam logic [31:0] STATUS_OFFSET    = 32'h0000_0000;
    localparam logic [31:0] MASK_OFFSET      = 32'h0000_0004;
    localparam logic [31:0] STATE_OFFSET     = 32'h0000_0008;
    localparam logic [31:0] TIMER_OFFSET     = 32'h0000_000C;
    localparam int          EV_FAST          = 0;
    localparam int          EV_DONE_SLOPE    = 1;
    localparam int          EV_DONE_TIMER    = 2;
    localparam int          EV_OVERTEMP      = 3;
    localparam int          EV_UVLO          = 4;
    localparam int          EV_W             = 5;
    localparam logic [4:0]  MASK_RESET       = 5'h00;

    typedef enum logic [2:0]
    {
        ST_TRICKLE = 3'b001,
        ST_FAST    = 3'b010,
        ST_LATCHED = 3'b100
    } mode_t;
endpackage

//--- src/charge_mode_control.sv
// charge mode state machine, backup timer, test bypasses and AHB-Lite status slave
//
// How it works
// - entering window selects fast, pulses reset
// - two slope events after holdoff latch trickle
// - latch clears on reset pulse or lockout
// - outside window forces trickle, not latched
// - timer backup allows fast below limit
// - timer limit reached latches trickle
// - undertemperature holds trickle, recovers unlatched
// - overtemperature sets latch until reset
// - lockout forces trickle, resets timer, latch
// - timer is 34 stage divider
// - switch 1 bypasses 19 stages
// - switch 2 bypasses 11 stages
// - section A speeds sample gate 32x
// - section B speeds holdoff 2048x
// - limit reached drives output low
// - three inputs pick seven limits
// - all grounded selects temperature backup
`timescale 1ns/1ns
module charge_mode_control
    import charge_mode_pkg::*;
#(
    parameter int OSC_HZ       = 125_000_000,
    parameter int HOLDOFF_BITS = HOLD_STAGES
)(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        sense_above_low_i,
    input  wire logic        sense_above_high_i,
    input  wire logic        supply_ok_i,
    input  wire logic        slope_event_i,
    input  wire logic        prog_input_upper_i,
    input  wire logic        prog_input_thermistor_i,
    input  wire logic        prog_input_lower_i,
    input  wire logic        upper_test_level_i,
    input  wire logic        under_temp_i,
    input  wire logic        over_temp_i,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             fast_charge_o,
    output logic             sample_gate_output_o,
    output logic             irq_o
);
    import charge_mode_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers: stage one feeds only stage two
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;
    logic [NSYNC-1:0] nxt_meta;
    always_comb
    begin
        nxt_meta = {sense_above_low_i, sense_above_high_i, supply_ok_i, slope_event_i,
                    prog_input_upper_i, prog_input_thermistor_i, prog_input_lower_i,
                    upper_test_level_i, under_temp_i, over_temp_i};
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= meta_ff;
        end
    end
    logic above_low;
    logic above_high;
    logic supply_ok;
    logic slope_ev;
    logic p_upper;
    logic p_therm;
    logic p_lower;
    logic test_lvl;
    logic under_t;
    logic over_t;
    assign {above_low, above_high, supply_ok, slope_ev, p_upper, p_therm, p_lower,
            test_lvl, under_t, over_t} = sync_ff;

    logic in_window;
    logic time_mode;
    logic sw1_on;
    logic sw2_on;
    logic sw3_on;
    assign in_window = above_low && !above_high;
    assign time_mode = p_upper || p_therm || p_lower;
    assign sw1_on    = !above_low;
    assign sw2_on    = !above_low && test_lvl;
    assign sw3_on    = test_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // edge detection, reset pulses and divider chains
    logic                    win_d_ff;
    logic                    sup_d_ff;
    logic                    slope_d_ff;
    logic [TIMER_STAGES-1:0] timer_ff;
    logic [GATE_STAGES-1:0]  gate_ff;
    logic [HOLDOFF_BITS-1:0] hold_ff;
    logic                    hold_done_ff;
    logic [1:0]              slope_cnt_ff;
    logic                    ot_latch_ff;
    logic                    nxt_win_d;
    logic                    nxt_sup_d;
    logic                    nxt_slope_d;
    logic [TIMER_STAGES-1:0] nxt_timer;
    logic [GATE_STAGES-1:0]  nxt_gate;
    logic [HOLDOFF_BITS-1:0] nxt_hold;
    logic                    nxt_hold_done;
    logic [1:0]              nxt_slope_cnt;
    logic                    nxt_ot_latch;
    logic                    reset_pulse;
    logic                    slope_rise;
    logic                    limit_hit;
    logic [2:0]              limit_sel;
    logic [31:0]             hold_sum;

    // one-clock pulses on window entry or supply recovery
    assign reset_pulse = (in_window && !win_d_ff) || (supply_ok && !sup_d_ff);
    assign slope_rise  = slope_ev && !slope_d_ff;
    assign limit_sel   = {p_lower, p_therm, p_upper};

    // limit expressed as timer word: top stage for 283 min, scaled by minutes
    function automatic logic [TIMER_STAGES-1:0] limit_count(input logic [2:0] sel);
        int minutes;
        logic [63:0] prod;
        begin
            unique case (sel)
                3'b111:  minutes = LIMIT_283_MIN;
                3'b110:  minutes = LIMIT_247_MIN;
                3'b101:  minutes = LIMIT_212_MIN;
                3'b100:  minutes = LIMIT_177_MIN;
                3'b011:  minutes = LIMIT_141_MIN;
                3'b010:  minutes = LIMIT_106_MIN;
                default: minutes = LIMIT_71_MIN;
            endcase
            prod = (64'(1) << (TIMER_STAGES - 1)) * 64'(minutes) / 64'(LIMIT_283_MIN);
            limit_count = prod[TIMER_STAGES-1:0];
        end
    endfunction

    // bypass switches scale the count step instead of rewiring stages;
    // switch 2 replaces switch 1 so the stages that switch 1 skips get exercised
    function automatic logic [TIMER_STAGES-1:0] step_of(input logic s1, input logic s2);
        begin
            step_of = s1 ? (TIMER_STAGES'(1) << (s2 ? SW2_BYPASS : SW1_BYPASS))
                         : TIMER_STAGES'(1);
        end
    endfunction

    assign limit_hit = time_mode && (timer_ff >= limit_count(limit_sel));

    // wide sum so the section B step still ends a holdoff counter shorter than the bypass
    assign hold_sum = 32'(hold_ff) + (sw3_on ? (32'(1) << HOLD_BYPASS) : 32'(1));

    always_comb
    begin
        nxt_win_d     = in_window;
        nxt_sup_d     = supply_ok;
        nxt_slope_d   = slope_ev;
        nxt_gate      = gate_ff + (sw3_on ? GATE_STAGES'(1) << GATE_BYPASS
                                          : GATE_STAGES'(1));
        nxt_timer     = timer_ff;
        nxt_hold      = hold_ff;
        nxt_hold_done = hold_done_ff;
        nxt_slope_cnt = slope_cnt_ff;
        nxt_ot_latch  = ot_latch_ff;
        if (!supply_ok || reset_pulse)
        begin
            nxt_timer     = '0;
            nxt_ot_latch  = 1'b0;
            nxt_hold      = '0;
            nxt_hold_done = 1'b0;
            nxt_slope_cnt = '0;
        end
        else
        begin
            if (!limit_hit)
                nxt_timer = timer_ff + step_of(sw1_on, sw2_on);
            if (!hold_done_ff)
            begin
                nxt_hold      = hold_sum[HOLDOFF_BITS-1:0];
                nxt_hold_done = |hold_sum[31:HOLDOFF_BITS];
            end
            if (!in_window)
                nxt_slope_cnt = '0;
            else if (hold_done_ff && slope_rise && slope_cnt_ff < 2'(SLOPE_EVENTS))
                nxt_slope_cnt = slope_cnt_ff + 2'd1;
            if (!time_mode && over_t)
                nxt_ot_latch = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            win_d_ff     <= 1'b0;
            sup_d_ff     <= 1'b0;
            slope_d_ff   <= 1'b0;
            timer_ff     <= '0;
            gate_ff      <= '0;
            hold_ff      <= '0;
            hold_done_ff <= 1'b0;
            slope_cnt_ff <= '0;
            ot_latch_ff  <= 1'b0;
        end
        else
        begin
            win_d_ff     <= nxt_win_d;
            sup_d_ff     <= nxt_sup_d;
            slope_d_ff   <= nxt_slope_d;
            timer_ff     <= nxt_timer;
            gate_ff      <= nxt_gate;
            hold_ff      <= nxt_hold;
            hold_done_ff <= nxt_hold_done;
            slope_cnt_ff <= nxt_slope_cnt;
            ot_latch_ff  <= nxt_ot_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode state machine
    mode_t mode_ff;
    mode_t nxt_mode;
    logic  latch_cause;
    logic  fast_ok;
    assign latch_cause = (slope_cnt_ff == 2'(SLOPE_EVENTS))
                      || limit_hit
                      || ot_latch_ff;
    assign fast_ok     = supply_ok && in_window && !(!time_mode && under_t);

    always_comb
    begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            ST_TRICKLE:
                if (fast_ok && !latch_cause && !reset_pulse)
                    nxt_mode = ST_FAST;
            ST_FAST:
                if (!supply_ok || !in_window)
                    nxt_mode = ST_TRICKLE;
                else if (latch_cause)
                    nxt_mode = ST_LATCHED;
                else if (!time_mode && under_t)
                    nxt_mode = ST_TRICKLE;
            ST_LATCHED:
                if (reset_pulse || !supply_ok)
                    nxt_mode = ST_TRICKLE;
            default:
                nxt_mode = ST_TRICKLE;
        endcase
    end

    logic fast_ff;
    logic gate_out_ff;
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mode_ff     <= ST_TRICKLE;
            fast_ff     <= 1'b0;
            gate_out_ff <= 1'b1;
        end
        else
        begin
            mode_ff     <= nxt_mode;
            fast_ff     <= (nxt_mode == ST_FAST);
            gate_out_ff <= ~&gate_ff[GATE_STAGES-1:GATE_STAGES-2];           // low briefly
        end
    end
    assign fast_charge_o        = fast_ff;
    assign sample_gate_output_o = gate_out_ff;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and AHB-Lite slave
    logic [EV_W-1:0] status_ff;
    logic [EV_W-1:0] mask_ff;
    logic [EV_W-1:0] nxt_status;
    logic [EV_W-1:0] nxt_mask;
    logic [EV_W-1:0] events;
    logic            wr_pend_ff;
    logic [3:0]      wr_addr_ff;
    logic            nxt_wr_pend;
    logic [3:0]      nxt_wr_addr;
    logic [31:0]     rdata_ff;
    logic [31:0]     nxt_rdata;
    logic            access;

    assign events[EV_FAST]       = (nxt_mode == ST_FAST) && (mode_ff != ST_FAST);
    assign events[EV_DONE_SLOPE] = (mode_ff == ST_FAST) && (nxt_mode == ST_LATCHED)
                                && (slope_cnt_ff == 2'(SLOPE_EVENTS));
    assign events[EV_DONE_TIMER] = (mode_ff == ST_FAST) && (nxt_mode == ST_LATCHED) && limit_hit;
    assign events[EV_OVERTEMP]   = nxt_ot_latch && !ot_latch_ff;
    assign events[EV_UVLO]       = !supply_ok && sup_d_ff;
    assign access = hsel && htrans[1] && hready;

    always_comb
    begin
        nxt_wr_pend = access && hwrite;
        nxt_wr_addr = access ? haddr[3:0] : wr_addr_ff;
        nxt_status  = status_ff;
        nxt_mask    = mask_ff;
        nxt_rdata   = rdata_ff;
        if (wr_pend_ff && wr_addr_ff == STATUS_OFFSET[3:0])
            nxt_status = status_ff & ~hwdata[EV_W-1:0];
        if (wr_pend_ff && wr_addr_ff == MASK_OFFSET[3:0])
            nxt_mask = hwdata[EV_W-1:0];
        nxt_status = nxt_status | events;   // set wins over clear
        if (access && !hwrite)
        begin
            unique case (haddr[3:0])
                STATUS_OFFSET[3:0]: nxt_rdata = {27'h0, status_ff};
                MASK_OFFSET[3:0]:   nxt_rdata = {27'h0, mask_ff};
                STATE_OFFSET[3:0]:  nxt_rdata = {24'h0, time_mode, ot_latch_ff,
                                                 slope_cnt_ff, 1'b0, mode_ff};
                TIMER_OFFSET[3:0]:  nxt_rdata = timer_ff[TIMER_STAGES-1:2];
                default:            nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            status_ff  <= '0;
            mask_ff    <= MASK_RESET;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            rdata_ff   <= '0;
        end
        else
        begin
            status_ff  <= nxt_status;
            mask_ff    <= nxt_mask;
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            rdata_ff   <= nxt_rdata;
        end
    end
    assign hrdata    = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq_o     = |(status_ff & mask_ff);
endmodule // charge_mode_control

//--- tb/charge_analog_model.sv
// comparator and detector model standing in for the analogue front end
`timescale 1ns/1ns
module charge_analog_model (
    input  wire logic [15:0] sense_mv_i,
    input  wire logic [15:0] supply_mv_i,
    input  wire logic        cold_i,
    input  wire logic        hot_i,
    input  wire logic        slope_i,
    output logic             above_low_o,
    output logic             above_high_o,
    output logic             supply_ok_o,
    output logic             slope_o,
    output logic             under_temp_o,
    output logic             over_temp_o
);
    always_comb
    begin
        above_low_o  = sense_mv_i > 16'h03E8;
        above_high_o = sense_mv_i > 16'h07D0;
        under_temp_o = cold_i;
        over_temp_o  = hot_i;
        slope_o      = slope_i;
    end
    // lockout keeps its hysteresis: between the levels the last state holds
    initial
    begin
        supply_ok_o = 1'b1;
        forever
        begin
            @(supply_mv_i);
            if (supply_mv_i > 16'h0BB8)
                supply_ok_o = 1'b1;
            else if (supply_mv_i < 16'h0AF0)
                supply_ok_o = 1'b0;
        end
    end
endmodule // charge_analog_model

//--- tb/charge_mode_control_monitor.sv
// port assertions for the charge mode control
`timescale 1ns/1ns
module charge_mode_control_monitor (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic sense_above_low_i,
    input wire logic sense_above_high_i,
    input wire logic supply_ok_i,
    input wire logic prog_input_upper_i,
    input wire logic prog_input_thermistor_i,
    input wire logic prog_input_lower_i,
    input wire logic under_temp_i,
    input wire logic over_temp_i,
    input wire logic fast_charge_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic tmode = !prog_input_upper_i && !prog_input_thermistor_i && !prog_input_lower_i;
    wire logic in_win = sense_above_low_i && !sense_above_high_i && supply_ok_i;
    sequence entry_s;
        !sense_above_low_i ##1 (in_win && !tmode)[*6];
    endsequence
    sequence hot_s;
        (in_win && tmode)[*4] ##1 (in_win && tmode && over_temp_i)[*3];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    low_out_a: assert property ((!sense_above_low_i)[*6] |=> !fast_charge_o)
        else $error("fast charge below the window");
    high_out_a: assert property (sense_above_high_i[*6] |=> !fast_charge_o)
        else $error("fast charge above the window");
    lockout_a: assert property ((!supply_ok_i)[*6] |=> !fast_charge_o)
        else $error("fast charge during lockout");
    enter_fast_a: assert property (entry_s |=> fast_charge_o)
        else $error("no fast charge after window entry");
    cold_hold_a: assert property ((in_win && tmode && under_temp_i)[*6] |=> !fast_charge_o)
        else $error("fast charge while too cold");
    hot_latch_a: assert property (hot_s ##1 (in_win && tmode)[*8] |=> !fast_charge_o)
        else $error("overtemperature did not latch trickle");
    fast_cause_a: assert property ($rose(fast_charge_o) |-> $past(in_win, 3))
        else $error("fast charge began outside the window");
    // output must not beat the two flop synchroniser
    sync_delay_a: assert property ($rose(sense_above_high_i) && fast_charge_o
        |-> fast_charge_o[*3] ##[1:3] !fast_charge_o)
        else $error("wrong delay from sense to output");
endmodule // charge_mode_control_monitor
bind charge_mode_control charge_mode_control_monitor mon (
    .core_clk_i, .rst_b_i, .sense_above_low_i, .sense_above_high_i, .supply_ok_i,
    .prog_input_upper_i, .prog_input_thermistor_i, .prog_input_lower_i,
    .under_temp_i, .over_temp_i, .fast_charge_o
);

//--- tb/charge_mode_control_test.sv
// self-checking bench for the charge mode control
`timescale 1ns/1ns
module charge_mode_control_test;
    import charge_mode_pkg::*;
    logic core_clk_i, rst_b_i, sense_above_low_i, sense_above_high_i, supply_ok_i;
    logic slope_event_i, prog_input_upper_i, prog_input_thermistor_i, prog_input_lower_i;
    logic upper_test_level_i, under_temp_i, over_temp_i, hsel, hwrite, hready;
    logic hreadyout, hresp, fast_charge_o, sample_gate_output_o, irq_o, cold, hot, slope_req;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q, t0;
    logic [15:0] sense_mv, supply_mv, rnd;
    int          n_fail, comparisons, n;
    assign hready = hreadyout;
    charge_mode_control #(.HOLDOFF_BITS(4)) DUT (
        .core_clk_i, .rst_b_i, .sense_above_low_i, .sense_above_high_i, .supply_ok_i,
        .slope_event_i, .prog_input_upper_i, .prog_input_thermistor_i, .prog_input_lower_i,
        .upper_test_level_i, .under_temp_i, .over_temp_i, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .fast_charge_o,
        .sample_gate_output_o, .irq_o
    );
    charge_analog_model model (
        .sense_mv_i(sense_mv), .supply_mv_i(supply_mv), .cold_i(cold), .hot_i(hot),
        .slope_i(slope_req), .above_low_o(sense_above_low_i),
        .above_high_o(sense_above_high_i), .supply_ok_o(supply_ok_i),
        .slope_o(slope_event_i), .under_temp_o(under_temp_i), .over_temp_o(over_temp_i)
    );
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // timer register shows bits 33:2, so the gain is the raw gain over four
    function automatic logic [31:0] timer_gain(input logic sw1, input logic sw2);
        logic [33:0] v;
        v = (sw2 ? 34'h800 : (sw1 ? 34'h80000 : 34'h1)) * 34'h8;
        return v[33:2];
    endfunction
    // switch 1 steps stop on the first step at or past the limit for these minutes
    function automatic logic [31:0] limit_steps(input int minutes);
        longint lim;
        lim = (longint'(1) << (TIMER_STAGES - 1)) * minutes / LIMIT_283_MIN;
        return 32'((lim + (longint'(1) << SW1_BYPASS) - 1) >> SW1_BYPASS);
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic fast_is(input logic e);
        check({31'h0, fast_charge_o}, {31'h0, e});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask
    task automatic wait_ready;
        int k;
        k = 0;
        do
        begin
            tick(1);
            k++;
        end
        while (hready !== 1'b1 && k < 20);
        if (hready !== 1'b1)
        begin
            n_fail++;
            final_report;
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        q = hrdata;
    endtask
    task automatic pick_prog;
        rnd = lfsr_next(rnd);
        {prog_input_lower_i, prog_input_thermistor_i, prog_input_upper_i} <=
            (rnd[2:0] == 3'h0) ? 3'h7 : rnd[2:0];
    endtask
    task automatic slope_pulse;
        slope_req <= 1'b1;
        tick(3);
        slope_req <= 1'b0;
        tick(5);
    endtask
    task automatic reenter;
        sense_mv <= 16'h02BC;
        tick(8);
        sense_mv <= 16'h05DC;
    endtask
    task automatic hot_blip;
        hot <= 1'b1;
        tick(4);
        hot <= 1'b0;
        tick(8);
    endtask
    // counts cycles until the gate output next goes low
    task automatic gate_fall;
        n = 0;
        while (sample_gate_output_o !== 1'b1 && n < 40000)
        begin
            tick(1);
            n++;
        end
        while (sample_gate_output_o !== 1'b0 && n < 40000)
        begin
            tick(1);
            n++;
        end
        if (n >= 40000)
        begin
            n_fail++;
            final_report;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        rnd = 16'hB760;
        n_fail = 0;
        comparisons = 0;
        rst_b_i = 1'b0;
        {hsel, hwrite, slope_req, cold, hot, upper_test_level_i} = 6'h00;
        {prog_input_lower_i, prog_input_thermistor_i, prog_input_upper_i} = 3'h7;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        sense_mv = 16'h02BC;
        supply_mv = 16'h1388;
        tick(2);
        check({27'h0, fast_charge_o, sample_gate_output_o, irq_o, hreadyout, hresp}, 32'hA);
        rst_b_i <= 1'b1;
        tick(4);
        bus(1'b0, MASK_OFFSET, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 32'h10, 32'hFFFF_FFFF);
        bus(1'b0, 32'h10, 32'h0);
        check(q, 32'h0);
        $display("reset test done");
        pick_prog;
        sense_mv <= 16'h05DC;
        tick(8);
        fast_is(1'b1);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        check(q & 32'h1, 32'h1);
        check({31'h0, irq_o}, 32'h0);
        bus(1'b1, MASK_OFFSET, 32'h1);
        tick(1);
        check({31'h0, irq_o}, 32'h1);
        bus(1'b1, STATUS_OFFSET, 32'h1);
        tick(1);
        check({31'h0, irq_o}, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            sense_mv <= (i == 0) ? 16'h09C4 : 16'h02BC;
            tick(8);
            fast_is(1'b0);
            sense_mv <= 16'h05DC;
            tick(8);
            fast_is(1'b1);
        end
        $display("window test done");
        reenter;
        tick(1);
        slope_pulse;
        slope_pulse;
        fast_is(1'b1);
        rnd = lfsr_next(rnd);
        tick(30 + int'(rnd[3:0]));
        slope_pulse;
        fast_is(1'b1);
        slope_pulse;
        fast_is(1'b0);
        bus(1'b0, STATE_OFFSET, 32'h0);
        check(q & 32'h7, 32'h4);
        supply_mv <= 16'h09C4;
        tick(8);
        fast_is(1'b0);
        bus(1'b0, TIMER_OFFSET, 32'h0);
        check(q, 32'h0);
        supply_mv <= 16'h1388;
        tick(8);
        fast_is(1'b1);
        $display("slope test done");
        {prog_input_lower_i, prog_input_thermistor_i, prog_input_upper_i} <= 3'h0;
        cold <= 1'b1;
        tick(8);
        fast_is(1'b0);
        cold <= 1'b0;
        tick(8);
        fast_is(1'b1);
        hot_blip;
        fast_is(1'b0);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        check(q & 32'h8, 32'h8);
        reenter;
        tick(8);
        fast_is(1'b1);
        pick_prog;
        hot_blip;
        fast_is(1'b1);
        $display("temperature test done");
        for (int i = 0; i < 3; i++)
        begin
            upper_test_level_i <= (i == 2);
            if (i == 1)
                sense_mv <= 16'h02BC;
            tick(6);
            bus(1'b0, TIMER_OFFSET, 32'h0);
            t0 = q;
            tick(6);
            bus(1'b0, TIMER_OFFSET, 32'h0);
            check(q - t0, timer_gain(i > 0, i == 2));
        end
        // shortest limit under switch 1: the count must freeze at the limit
        upper_test_level_i <= 1'b0;
        {prog_input_lower_i, prog_input_thermistor_i, prog_input_upper_i} <= 3'h1;
        tick(4200);
        bus(1'b0, TIMER_OFFSET, 32'h0);
        t0 = q;
        tick(8);
        bus(1'b0, TIMER_OFFSET, 32'h0);
        check(q, t0);
        check(q >> (SW1_BYPASS - 2), limit_steps(LIMIT_71_MIN));
        $display("timer test done");
        // section B ends the holdoff at once, so early slope events now count
        upper_test_level_i <= 1'b1;
        reenter;
        tick(4);
        slope_pulse;
        slope_pulse;
        fast_is(1'b0);
        $display("holdoff test done");
        gate_fall;
        gate_fall;
        check(n, 32'h8000);
        $display("gate test done");
        final_report;
    end
endmodule // charge_mode_control_test
